//--- common/mpsm_params.svh
`ifndef MPSM_PARAMS_SVH
`define MPSM_PARAMS_SVH
// register word indices on the bus, byte offset is four times the index
`define MPSM_IDX_CTRL 4'h0
`define MPSM_IDX_STATUS 4'h1
`define MPSM_IDX_FSEL 4'h2
`define MPSM_IDX_GPIO_OUT 4'h3
`define MPSM_IDX_GPIO_OE 4'h4
`define MPSM_IDX_GPIO_IN 4'h5
`define MPSM_IDX_PD_OVR_EN 4'h6
`define MPSM_IDX_PD_OVR_DRV 4'h7
`define MPSM_IDX_PD_OVR_VAL 4'h8
`define MPSM_IDX_PULLUP_EN 4'h9
`define MPSM_IDX_PULLDN_EN 4'hA
`define MPSM_IDX_PULL_WEAK 4'hB
// control register fields
`define MPSM_CTRL_FUNC 0
`define MPSM_CTRL_AUDIO_MASTER 1
`define MPSM_CTRL_MCLK_EN 2
// per-pin pad state tables, bit n is pin n
`define MPSM_RST_DRV 32'h01608A01
`define MPSM_RST_VAL 32'h00600A01
`define MPSM_HW_DRV 32'h01608A01
`define MPSM_HW_VAL 32'h01000A01
`define MPSM_HW_VAL_UART 32'h01000201
`define MPSM_PD_DRV 32'h043AAA01
`define MPSM_PD_VAL 32'h00002200
`define MPSM_PULL_WEAK 32'h89050070
`define MPSM_ALT_CAP 32'hFEBFFFFF
`define MPSM_ALT_OUT 32'h842A4A29
`define MPSM_MCLK_PIN 32'h00000008
// reset values of software registers
`define MPSM_FSEL_RST 32'h00000000
`define MPSM_PULLUP_RST 32'hFFFFFFFF
`define MPSM_PULLDN_RST 32'h00000000
`endif

//--- common/mpsm_pkg.sv
package mpsm_pkg;
	typedef enum logic [1:0] {
		MPSM_PH_RESET = 2'b00,
		MPSM_PH_POSTBOOT = 2'b01,
		MPSM_PH_FUNC = 2'b10
	} mpsm_phase_t;
	// alternate-function signals driven by the internal subsystems
	typedef struct packed {
		logic test_data_out;
		logic iso_trigger_2;
		logic iso_trigger_2_oe;
		logic coex_serial_out;
		logic iso_trigger_1;
		logic iso_trigger_1_oe;
		logic sdio_irq_out;
		logic pan_wake_out;
		logic wlan_wake_out;
		logic coex_grant_out;
		logic uart_tx;
		logic uart_rts_n;
		logic audio_sync;
		logic audio_dout;
		logic audio_bclk;
		logic codec_master_clock;
		logic osc_enable_out;
	} mpsm_core_out_t;
	// alternate-function signals received from the pads
	typedef struct packed {
		logic test_data_in;
		logic test_mode_sel;
		logic test_clock;
		logic iso_trigger_2;
		logic coex_serial_in;
		logic iso_trigger_1;
		logic coex_freq_overlap_in;
		logic pan_wake_in;
		logic wlan_wake_in;
		logic coex_priority_in;
		logic coex_request_in;
		logic coex_direction_in;
		logic uart_rx;
		logic uart_cts_n;
		logic audio_sync;
		logic audio_din;
		logic audio_bclk;
		logic pan_radio_reset_in;
		logic wlan_reset_in;
	} mpsm_core_in_t;
endpackage : mpsm_pkg

//--- core/mpsm_top.sv
// Notes on behaviour
// - pads hold reset-phase state until boot done
// - post-boot state holds until firmware takes over
// - uart strap: rts high, serial out low
// - default power-down state, programmable override
// - pulls only act while pad is input
// - independent pull-up/pull-down enables, default up
// - firmware switches pads into functional mode
// - pins 31..28 test access port
// - pins 27, 23 isochronous trigger lines
// - pins 26, 25 serial coexistence
// - pins 24, 22 fixed reset/post-boot levels
// - pin 21 sdio interrupt output
// - five-wire coexistence on pins 20, 15..12
// - wake lines on pins 19..16
// - pins 11, 9 uart outputs
// - pins 10, 8 uart inputs from host
// - audio clocks follow master/slave, data pins
// - pin 3 optional codec master clock
// - pins 2, 1 independent reset inputs
// - pin 0 oscillator enable output
//
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "mpsm_params.svh"
module mpsm_top
	import mpsm_pkg::*;
#(
	parameter int PINS = 32
)
(
	input wire logic clk_sys, // core clock
	input wire logic rst, // power-on reset, async high
	input wire logic boot_done, // boot code finished
	input wire logic power_down_req, // power controller asks for sleep
	input wire logic strap_sdio_uart, // host strap pin
	input wire logic [PINS-1:0] pad_in, // pad receivers
	output logic [PINS-1:0] pad_out, // pad drive value
	output logic [PINS-1:0] pad_oe_n, // low drives the pad
	output logic [PINS-1:0] pad_pull_up, // pull-up active
	output logic [PINS-1:0] pad_pull_down, // pull-down active
	output logic [PINS-1:0] pad_pull_weak, // pull strength weak
	input wire mpsm_core_out_t core_out, // subsystem outputs
	output mpsm_core_in_t core_in, // subsystem inputs
	input wire logic [3:0] avs_address, // word address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest // high holds the master
);

	typedef struct packed {
		mpsm_phase_t phase;
		logic strap;
		logic audio_master;
		logic mclk_en;
		logic [PINS-1:0] fsel;
		logic [PINS-1:0] gpio_out;
		logic [PINS-1:0] gpio_oe;
		logic [PINS-1:0] ovr_en;
		logic [PINS-1:0] ovr_drv;
		logic [PINS-1:0] ovr_val;
		logic [PINS-1:0] pu_en;
		logic [PINS-1:0] pdn_en;
		logic [PINS-1:0] pad_s1;
		logic [PINS-1:0] pad_s2;
		logic strap_s1;
		logic strap_s2;
		logic wait_r;
		logic [31:0] rdata;
		logic [PINS-1:0] pad_o;
		logic [PINS-1:0] pad_oe_n;
		logic [PINS-1:0] pu_o;
		logic [PINS-1:0] pd_o;
		logic [PINS-1:0] weak_o;
		mpsm_core_in_t cin;
	} mpsm_state_t;

	mpsm_state_t q;
	mpsm_state_t d;

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] mpsm_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0] be
	);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
			begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : mpsm_merge

	always_comb
	begin
		logic req;
		logic wr_take;
		logic [31:0] wd;
		logic [PINS-1:0] alt_o;
		logic [PINS-1:0] alt_oe;
		logic [PINS-1:0] sel;
		logic [PINS-1:0] drv;
		logic [PINS-1:0] val;
		logic [PINS-1:0] s;
		req = 1'b0;
		wr_take = 1'b0;
		wd = '0;
		alt_o = '0;
		alt_oe = '0;
		sel = '0;
		drv = '0;
		val = '0;
		s = '0;
		d = q;

		// pad and strap synchronisers
		d.pad_s1 = pad_in;
		d.pad_s2 = q.pad_s1;
		d.strap_s1 = strap_sdio_uart;
		d.strap_s2 = q.strap_s1;
		s = q.pad_s2;

		// pad-state phase sequencing
		if (q.phase == MPSM_PH_RESET && boot_done)
		begin
			d.phase = MPSM_PH_POSTBOOT;
			d.strap = q.strap_s2;
		end
		// an illegal phase code falls back to the reset phase
		if (q.phase != MPSM_PH_RESET && q.phase != MPSM_PH_POSTBOOT &&
			q.phase != MPSM_PH_FUNC)
		begin
			d.phase = MPSM_PH_RESET;
		end

		// bus slave: one wait cycle, then the answer
		req = avs_read | avs_write;
		d.wait_r = !(req && q.wait_r);
		// writes only land in the answer cycle
		wr_take = avs_write && !q.wait_r;
		// only reads load read data, so it holds across writes
		if (avs_read && q.wait_r)
		begin
			d.rdata = '0;
			case (avs_address)
				`MPSM_IDX_CTRL:
				begin
					d.rdata[`MPSM_CTRL_FUNC] = q.phase == MPSM_PH_FUNC;
					d.rdata[`MPSM_CTRL_AUDIO_MASTER] = q.audio_master;
					d.rdata[`MPSM_CTRL_MCLK_EN] = q.mclk_en;
				end
				`MPSM_IDX_STATUS:
				begin
					d.rdata[1:0] = q.phase;
					d.rdata[2] = q.strap;
					d.rdata[3] = power_down_req;
				end
				`MPSM_IDX_FSEL: d.rdata = q.fsel;
				`MPSM_IDX_GPIO_OUT: d.rdata = q.gpio_out;
				`MPSM_IDX_GPIO_OE: d.rdata = q.gpio_oe;
				`MPSM_IDX_GPIO_IN: d.rdata = s;
				`MPSM_IDX_PD_OVR_EN: d.rdata = q.ovr_en;
				`MPSM_IDX_PD_OVR_DRV: d.rdata = q.ovr_drv;
				`MPSM_IDX_PD_OVR_VAL: d.rdata = q.ovr_val;
				`MPSM_IDX_PULLUP_EN: d.rdata = q.pu_en;
				`MPSM_IDX_PULLDN_EN: d.rdata = q.pdn_en;
				`MPSM_IDX_PULL_WEAK: d.rdata = q.weak_o;
				default: d.rdata = '0;
			endcase
		end
		if (wr_take)
		begin
			wd = avs_writedata;
			case (avs_address)
				`MPSM_IDX_CTRL:
				begin
					if (avs_byteenable[0])
					begin
						// firmware ready: leave post-boot state
						if (wd[`MPSM_CTRL_FUNC] &&
							q.phase == MPSM_PH_POSTBOOT)
						begin
							d.phase = MPSM_PH_FUNC;
						end
						d.audio_master = wd[`MPSM_CTRL_AUDIO_MASTER];
						d.mclk_en = wd[`MPSM_CTRL_MCLK_EN];
					end
				end
				`MPSM_IDX_FSEL:
					d.fsel = mpsm_merge(q.fsel, wd, avs_byteenable);
				`MPSM_IDX_GPIO_OUT:
					d.gpio_out = mpsm_merge(q.gpio_out, wd, avs_byteenable);
				`MPSM_IDX_GPIO_OE:
					d.gpio_oe = mpsm_merge(q.gpio_oe, wd, avs_byteenable);
				`MPSM_IDX_PD_OVR_EN:
					d.ovr_en = mpsm_merge(q.ovr_en, wd, avs_byteenable);
				`MPSM_IDX_PD_OVR_DRV:
					d.ovr_drv = mpsm_merge(q.ovr_drv, wd, avs_byteenable);
				`MPSM_IDX_PD_OVR_VAL:
					d.ovr_val = mpsm_merge(q.ovr_val, wd, avs_byteenable);
				`MPSM_IDX_PULLUP_EN:
					d.pu_en = mpsm_merge(q.pu_en, wd, avs_byteenable);
				`MPSM_IDX_PULLDN_EN:
					d.pdn_en = mpsm_merge(q.pdn_en, wd, avs_byteenable);
				default:
				begin
				end
			endcase
		end

		// alternate-function outputs and their directions
		alt_oe = `MPSM_ALT_OUT;
		alt_o[31] = core_out.test_data_out;
		alt_o[27] = core_out.iso_trigger_2;
		alt_oe[27] = core_out.iso_trigger_2_oe;
		alt_o[26] = core_out.coex_serial_out;
		alt_o[23] = core_out.iso_trigger_1;
		alt_oe[23] = core_out.iso_trigger_1_oe;
		alt_o[21] = core_out.sdio_irq_out;
		alt_o[19] = core_out.pan_wake_out;
		alt_o[17] = core_out.wlan_wake_out;
		alt_o[14] = core_out.coex_grant_out;
		alt_o[11] = core_out.uart_tx;
		alt_o[9] = core_out.uart_rts_n;
		alt_o[7] = core_out.audio_sync;
		alt_oe[7] = q.audio_master;
		alt_o[5] = core_out.audio_dout;
		alt_o[4] = core_out.audio_bclk;
		alt_oe[4] = q.audio_master;
		alt_o[3] = core_out.codec_master_clock;
		alt_o[0] = core_out.osc_enable_out;

		// pins 24 and 22 have no alternate; pin 3 only with clock enabled
		sel = q.fsel & `MPSM_ALT_CAP;
		if (!q.mclk_en)
		begin
			sel = sel & ~`MPSM_MCLK_PIN;
		end
		if (q.phase != MPSM_PH_FUNC)
		begin
			sel = '0;
		end

		unique case (q.phase)
			MPSM_PH_RESET:
			begin
				drv = `MPSM_RST_DRV;
				val = `MPSM_RST_VAL;
			end
			MPSM_PH_POSTBOOT:
			begin
				drv = `MPSM_HW_DRV;
				val = q.strap ? `MPSM_HW_VAL_UART : `MPSM_HW_VAL;
			end
			MPSM_PH_FUNC:
			begin
				drv = (sel & alt_oe) | (~sel & q.gpio_oe);
				val = (sel & alt_o) | (~sel & q.gpio_out);
			end
			// illegal code: show the reset-phase levels
			default:
			begin
				drv = `MPSM_RST_DRV;
				val = `MPSM_RST_VAL;
			end
		endcase

		// power-down overrides every phase but the reset phase
		if (power_down_req && q.phase != MPSM_PH_RESET)
		begin
			drv = (q.ovr_en & q.ovr_drv) |
				(~q.ovr_en & `MPSM_PD_DRV);
			val = (q.ovr_en & q.ovr_val) |
				(~q.ovr_en & `MPSM_PD_VAL);
			sel = '0;
		end

		// pulls follow the driver so a pad never fights its own resistor
		d.pad_oe_n = ~drv;
		d.pad_o = val & drv;
		d.pu_o = q.pu_en & ~drv;
		d.pd_o = q.pdn_en & ~drv;

		// pad inputs to the subsystems, idle level when not selected
		d.cin.test_data_in = sel[30] & s[30];
		d.cin.test_mode_sel = sel[29] & s[29];
		d.cin.test_clock = sel[28] & s[28];
		d.cin.iso_trigger_2 = sel[27] & s[27];
		d.cin.coex_serial_in = sel[25] & s[25];
		d.cin.iso_trigger_1 = sel[23] & s[23];
		d.cin.coex_freq_overlap_in = sel[20] & s[20];
		d.cin.pan_wake_in = sel[18] & s[18];
		d.cin.wlan_wake_in = sel[16] & s[16];
		d.cin.coex_priority_in = sel[15] & s[15];
		d.cin.coex_request_in = sel[13] & s[13];
		d.cin.coex_direction_in = sel[12] & s[12];
		d.cin.uart_rx = sel[10] ? s[10] : 1'b1;
		d.cin.uart_cts_n = sel[8] ? s[8] : 1'b1;
		d.cin.audio_sync = sel[7] & s[7];
		d.cin.audio_din = sel[6] & s[6];
		d.cin.audio_bclk = sel[4] & s[4];
		d.cin.pan_radio_reset_in = sel[2] & s[2];
		d.cin.wlan_reset_in = sel[1] & s[1];
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			q <= '0;
			q.phase <= MPSM_PH_RESET;
			q.fsel <= `MPSM_FSEL_RST;
			q.pu_en <= `MPSM_PULLUP_RST;
			q.pdn_en <= `MPSM_PULLDN_RST;
			q.wait_r <= 1'b1;
			q.pad_oe_n <= ~`MPSM_RST_DRV;
			q.pad_o <= `MPSM_RST_VAL;
			q.pu_o <= `MPSM_PULLUP_RST & ~`MPSM_RST_DRV;
			q.weak_o <= `MPSM_PULL_WEAK;
			q.cin.uart_rx <= 1'b1;
			q.cin.uart_cts_n <= 1'b1;
		end
		else
		begin
			q <= d;
		end
	end

	assign pad_out = q.pad_o;
	assign pad_oe_n = q.pad_oe_n;
	assign pad_pull_up = q.pu_o;
	assign pad_pull_down = q.pd_o;
	assign pad_pull_weak = q.weak_o;
	assign core_in = q.cin;
	assign avs_readdata = q.rdata;
	assign avs_waitrequest = q.wait_r;

endmodule : mpsm_top

//--- bench/mpsm_pad_model.sv
`timescale 1ns/1ps
module mpsm_pad_model (
	input wire logic clk_sys, // clock
	input wire logic [31:0] pad_out, // device value
	input wire logic [31:0] pad_oe_n, // low: device drives
	input wire logic [31:0] pad_pull_up, // pull-up on
	input wire logic [31:0] pad_pull_down, // pull-down on
	input wire logic [31:0] ext_drv, // far side drives
	input wire logic [31:0] ext_val, // far-side level
	output logic [31:0] pad_in // wire level
);
	logic flip_q = 1'b0;
	always @(posedge clk_sys)
		flip_q <= ~flip_q;
	always_comb
	begin
		for (int n = 0; n < 32; n++)
		begin
			if (!pad_oe_n[n])
				pad_in[n] = pad_out[n];
			else if (ext_drv[n])
				pad_in[n] = ext_val[n];
			else if (pad_pull_up[n] || pad_pull_down[n])
				pad_in[n] = pad_pull_up[n];
			else
				pad_in[n] = flip_q; // floating wire wanders
		end
	end
endmodule : mpsm_pad_model

//--- bench/mpsm_top_chk.sv
`timescale 1ns/1ps
`include "mpsm_params.svh"
module mpsm_top_chk #(
	parameter int PINS = 32
)
(
	input wire logic clk_sys, // clock
	input wire logic rst, // reset
	input wire logic boot_done, // boot end
	input wire logic power_down_req, // sleep
	input wire logic avs_read, // read
	input wire logic avs_write, // write
	input wire logic [31:0] avs_readdata, // data
	input wire logic avs_waitrequest, // stall
	input wire logic [PINS-1:0] pad_out, // value
	input wire logic [PINS-1:0] pad_oe_n, // enable
	input wire logic [PINS-1:0] pad_pull_up, // up
	input wire logic [PINS-1:0] pad_pull_down, // down
	input wire logic [PINS-1:0] pad_pull_weak // weak
);
	logic booted_q;
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			booted_q <= 1'b0;
		else if (boot_done)
			booted_q <= 1'b1;
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	sequence s_request;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_answer;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	sequence s_boot;
		boot_done && !booted_q && !power_down_req ##1 !power_down_req;
	endsequence
	a_bus_one_wait: assert property (s_request |=> s_answer)
		else $error("bus answer late or long");
	a_readdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved");
	a_pull_up_input: assert property ((pad_pull_up & ~pad_oe_n) == '0)
		else $error("pull-up on driven pad");
	a_pull_dn_input: assert property ((pad_pull_down & ~pad_oe_n) == '0)
		else $error("pull-down on driven pad");
	a_weak_fixed: assert property (pad_pull_weak == `MPSM_PULL_WEAK)
		else $error("pull strength wrong");
	a_undriven_zero: assert property ((pad_out & pad_oe_n) == '0)
		else $error("value on released pad");
	a_reset_levels: assert property ($past(rst) |->
		pad_oe_n == ~(`MPSM_RST_DRV) && pad_out == `MPSM_RST_VAL)
		else $error("reset pad state wrong");
	a_boot_postboot_pad_state: assert property (s_boot |=>
		(pad_out & 32'h01600000) == 32'h01000000)
		else $error("post-boot pad state wrong");
endmodule : mpsm_top_chk
bind mpsm_top mpsm_top_chk #(.PINS(PINS)) u_chk (
	.clk_sys,
	.rst,
	.boot_done,
	.power_down_req,
	.avs_read,
	.avs_write,
	.avs_readdata,
	.avs_waitrequest,
	.pad_out,
	.pad_oe_n,
	.pad_pull_up,
	.pad_pull_down,
	.pad_pull_weak
);

//--- bench/mpsm_top_tb.sv
`timescale 1ns/1ps
`include "mpsm_params.svh"
module mpsm_top_tb
	import mpsm_pkg::*;
;
	logic clk_sys = 1'b0, rst = 1'b1, boot_done = 1'b0;
	logic power_down_req = 1'b0, strap_sdio_uart = 1'b0;
	logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, pad_in, pad_out;
	logic [31:0] pad_oe_n, pad_pull_up, pad_pull_down, pad_pull_weak;
	logic [31:0] ext_drv = 32'h0, ext_val = 32'h0;
	mpsm_core_out_t core_out = '0;
	mpsm_core_in_t core_in;
	int num_errors = 0, comparisons = 0, cycles = 0;
	initial
		forever #5 clk_sys = ~clk_sys;
	mpsm_top dut (.clk_sys, .rst, .boot_done, .power_down_req,
		.strap_sdio_uart, .pad_in, .pad_out, .pad_oe_n, .pad_pull_up,
		.pad_pull_down, .pad_pull_weak, .core_out, .core_in, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest);
	mpsm_pad_model far (.clk_sys, .pad_out, .pad_oe_n, .pad_pull_up,
		.pad_pull_down, .ext_drv, .ext_val, .pad_in);
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk_sys);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask : bus
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 4000)
		begin
			num_errors = num_errors + 1;
			tally_and_finish();
		end
	end
	initial
	begin
		for (int s = 0; s < 2; s++)
		begin
			rst <= 1'b1;
			strap_sdio_uart <= s[0];
			repeat (4) @(posedge clk_sys);
			rst <= 1'b0;
			repeat (3) @(posedge clk_sys);
			chk(~pad_oe_n, 32'h01608A01);
			chk(pad_out, 32'h00600A01);
			chk(pad_pull_up, 32'hFE9F75FE);
			chk(pad_pull_down, 32'h0);
			chk({13'h0, core_in}, 32'h00000060);
			bus(1'b1, 4'hC, 32'hFFFFFFFF);
			bus(1'b0, 4'hC, 32'h0);
			chk(rd, 32'h0);
			bus(1'b1, `MPSM_IDX_PULL_WEAK, 32'h0);
			bus(1'b0, `MPSM_IDX_PULL_WEAK, 32'h0);
			chk(rd, 32'h89050070);
			bus(1'b0, `MPSM_IDX_FSEL, 32'h0);
			chk(rd, 32'h0);
			boot_done <= 1'b1;
			@(posedge clk_sys);
			boot_done <= 1'b0;
			repeat (3) @(posedge clk_sys);
			chk(pad_out, s ? 32'h01000201 : 32'h01000A01);
		end
		power_down_req <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk(~pad_oe_n, 32'h043AAA01);
		chk(pad_out, 32'h00002200);
		bus(1'b1, `MPSM_IDX_PD_OVR_EN, 32'h80000001);
		bus(1'b1, `MPSM_IDX_PD_OVR_DRV, 32'h80000001);
		bus(1'b1, `MPSM_IDX_PD_OVR_VAL, 32'h80000001);
		repeat (3) @(posedge clk_sys);
		chk(~pad_oe_n, 32'h843AAA01);
		chk(pad_out, 32'h80002201);
		power_down_req <= 1'b0;
		bus(1'b1, `MPSM_IDX_CTRL, 32'h1);
		bus(1'b0, `MPSM_IDX_STATUS, 32'h0);
		chk(rd, 32'h6);
		ext_drv <= 32'hFFFFFFFF;
		ext_val <= 32'hC3C30000;
		bus(1'b1, `MPSM_IDX_GPIO_OE, 32'h0000FFFF);
		bus(1'b1, `MPSM_IDX_GPIO_OUT, 32'h0000A5A5);
		bus(1'b1, `MPSM_IDX_PULLUP_EN, 32'h00FF00FF);
		bus(1'b1, `MPSM_IDX_PULLDN_EN, 32'hFF00FF00);
		repeat (3) @(posedge clk_sys);
		chk(~pad_oe_n, 32'h0000FFFF);
		chk(pad_out, 32'h0000A5A5);
		chk(pad_pull_up, 32'h00FF0000);
		chk(pad_pull_down, 32'hFF000000);
		bus(1'b0, `MPSM_IDX_GPIO_IN, 32'h0);
		chk(rd, 32'hC3C3A5A5);
		bus(1'b1, `MPSM_IDX_GPIO_OE, 32'h0);
		bus(1'b1, `MPSM_IDX_FSEL, 32'hFFFFFFFF);
		for (int v = 0; v < 2; v++)
		begin
			core_out <= v[0] ? '1 : '0;
			ext_val <= {32{v[0]}};
			bus(1'b1, `MPSM_IDX_CTRL, v ? 32'h7 : 32'h1);
			repeat (4) @(posedge clk_sys);
			chk(~pad_oe_n, v ? 32'h8CAA4AB9 : 32'h842A4A21);
			chk(pad_out, v ? 32'h8CAA4AB9 : 32'h0);
			chk({13'h0, core_in}, v ? 32'h0007FFFF : 32'h0);
		end
		tally_and_finish();
	end
endmodule : mpsm_top_tb
